// >>> design/wdog_pkg.sv
// Constants, field layout and carrier types for the watchdog with timed configuration
// Notes on behaviour
// - Lower level: starts off, enable anytime
// - Lower level disable: unlock write, then write
// - Higher level: always running, enable reads one
// - Higher level: period changed by timed sequence
// - Higher level never disables the watchdog
// - Unlock bit self-clears after four cycles
// - Enable cleared only while unlock set
// - Period changes only while unlock set
// - Lower level: dog reset flag forces enable
// - Dog reset flag: set, POR/zero clear
// - Brown-out flag: set, POR/zero clear
// - Pin reset flag: set, POR/zero clear
// - Power-on flag cleared only by zero write
// - Cause register upper nibble reads zero
// - Irq flag set; vector or one clears
// - Irq needs global and local enables
// - Action table: none, interrupt or reset
// - Enable plus irq-enable: hardware clears irq-enable
// - Period code selects 2K..1024K oscillator cycles
// - Control register bit positions as listed
// - Counter runs from 128 kHz oscillator
// - Counter restarts on restart, disable, reset
// - Fuse selects safety level
package wdog_pkg;
    // ****************************************
    // Register map (index, byte address = 4 x index)
    // ****************************************
    localparam logic [7:0] CTL_IDX  = 8'h21;
    localparam logic [7:0] RC_IDX   = 8'h22;
    localparam logic [7:0] CTL_ADDR = 8'(CTL_IDX * 4);
    localparam logic [7:0] RC_ADDR  = 8'(RC_IDX * 4);
    // ****************************************
    // Field positions
    // ****************************************
    localparam int IRQF_BIT = 7;
    localparam int IE_BIT   = 6;
    localparam int P3_BIT   = 5;
    localparam int UNL_BIT  = 4;
    localparam int RUN_BIT  = 3;
    localparam int DOG_BIT  = 3;
    localparam int BO_BIT   = 2;
    localparam int PIN_BIT  = 1;
    localparam int POR_BIT  = 0;
    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [3:0]  PERIOD_RST   = 4'h0;
    localparam logic [3:0]  PERIOD_MAX   = 4'h9;
    localparam logic [2:0]  UNLOCK_CYC   = 3'h4;
    localparam logic [20:0] BASE_CYCLES  = 21'h0_0800;
    localparam int          OSC_HZ       = 128000;
    // Reset events reported by the reset controller, one-cycle pulses
    typedef struct packed {
        logic dog;
        logic brownout;
        logic pin;
    } reset_event_t;
endpackage

// >>> design/wdog_timed_config.sv
// Watchdog timer with fuse-selected safety level, timed unlock and reset-cause flags
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module wdog_timed_config (
    input  wire logic                  hclk,             // System clock, 20 MHz
    input  wire logic                  hresetn,          // Power-on reset, async, low
    input  wire logic                  clk_en,           // Freezes all state when low
    input  wire logic                  hsel,             // AHB slave select
    input  wire logic [7:0]            haddr,            // AHB byte address, low bits
    input  wire logic [1:0]            htrans,           // AHB transfer type
    input  wire logic                  hwrite,           // AHB write
    input  wire logic [2:0]            hsize,            // AHB size, word only
    input  wire logic [31:0]           hwdata,           // AHB write data
    input  wire logic                  hready,           // AHB bus ready
    output logic                       hreadyout,        // AHB slave ready
    output logic                       hresp,            // AHB response, OKAY
    output logic [31:0]                hrdata,           // AHB read data
    input  wire logic                  safety_level_fuse,// Fuse, high = programmed
    input  wire logic                  wdog_osc,         // 128 kHz oscillator, async
    input  wire logic                  dog_restart,      // Restart instruction pulse
    input  wire logic                  global_irq_en,    // Status register I bit
    input  wire logic                  irq_vector_ack,   // Vector taken pulse
    input  wire logic                  chip_reset,       // Non-power-on chip reset pulse
    input  wire wdog_pkg::reset_event_t reset_event,     // Reset cause pulses
    output logic                       timeout_irq,      // Interrupt request, level
    output logic                       dog_reset_req,    // Reset request, one cycle
    output logic                       wdog_running      // Counter running
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic        wr_q;
    logic [7:0]  addr_q;
    logic [31:0] hrdata_q;
    logic        acc;
    logic        wr_ctl;
    logic        wr_rc;
    logic [7:0]  wd;
    logic [7:0]  ctl_rd;
    logic [7:0]  rc_rd;

    // Zero wait states; a frozen block holds the bus off
    assign hreadyout = clk_en;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign acc       = hsel & hready & htrans[1];
    assign wd        = hwdata[7:0];
    assign wr_ctl    = wr_q && (addr_q == wdog_pkg::CTL_ADDR);
    assign wr_rc     = wr_q && (addr_q == wdog_pkg::RC_ADDR);

    // Address phase capture; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
        end else if (clk_en) begin
            wr_q   <= acc & hwrite;
            addr_q <= haddr;
        end
    end

    // Read data sampled at the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (clk_en && acc && !hwrite) begin
            if (haddr == wdog_pkg::CTL_ADDR) begin
                hrdata_q <= {24'h00_0000, ctl_rd};
            end else if (haddr == wdog_pkg::RC_ADDR) begin
                hrdata_q <= {24'h00_0000, rc_rd};
            end else begin
                hrdata_q <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // Synchronisers for fuse and oscillator
    // ****************************************
    logic fuse_s1_q;
    logic fuse_s2_q;
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic lvl2;
    logic tick;

    // Both arrive from outside the clock domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
            osc_s1_q  <= 1'b0;
            osc_s2_q  <= 1'b0;
            osc_s3_q  <= 1'b0;
        end else if (clk_en) begin
            fuse_s1_q <= safety_level_fuse;
            fuse_s2_q <= fuse_s1_q;
            osc_s1_q  <= wdog_osc;
            osc_s2_q  <= osc_s1_q;
            osc_s3_q  <= osc_s2_q;
        end
    end

    assign lvl2 = fuse_s2_q;
    assign tick = osc_s2_q & ~osc_s3_q;

    // ****************************************
    // Control register state
    // ****************************************
    logic       wde_q;
    logic       ie_q;
    logic       irqf_q;
    logic       unlock_q;
    logic [2:0] ucnt_q;
    logic [3:0] period_q;
    logic [2:0] rc_q;
    logic       por_q;
    logic       wde_eff;
    logic       running;
    logic       timeout;
    logic       open_now;

    // Higher level pins enable high; the lower level lets the dog flag hold it
    assign wde_eff  = lvl2 | wde_q | rc_q[wdog_pkg::DOG_BIT-1];
    assign running  = wde_eff | ie_q;
    assign open_now = wr_ctl && wd[wdog_pkg::UNL_BIT] && wd[wdog_pkg::RUN_BIT];
    assign ctl_rd   = {irqf_q, ie_q, period_q[3], unlock_q, wde_eff, period_q[2:0]};
    assign rc_rd    = {4'h0, rc_q, por_q};

    // Enable: set freely, cleared only inside the unlock window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wde_q <= 1'b0;
        end else if (clk_en) begin
            if (chip_reset) begin
                wde_q <= 1'b0;
            end else if (wr_ctl) begin
                if (wd[wdog_pkg::RUN_BIT]) begin
                    wde_q <= 1'b1;
                end else if (unlock_q) begin
                    wde_q <= 1'b0;
                end
            end
        end
    end

    // Unlock window: four cycles from the opening write, then closes itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_q <= 1'b0;
            ucnt_q   <= 3'h0;
        end else if (clk_en) begin
            if (chip_reset) begin
                unlock_q <= 1'b0;
                ucnt_q   <= 3'h0;
            end else if (open_now) begin
                unlock_q <= 1'b1;
                ucnt_q   <= wdog_pkg::UNLOCK_CYC;
            end else if (unlock_q) begin
                ucnt_q <= ucnt_q - 3'h1;
                if (ucnt_q == 3'h1) begin
                    unlock_q <= 1'b0;
                end
            end
        end
    end

    // Period only moves inside the window; reserved codes act as the longest
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_q <= wdog_pkg::PERIOD_RST;
        end else if (clk_en) begin
            if (chip_reset) begin
                period_q <= wdog_pkg::PERIOD_RST;
            end else if (wr_ctl && unlock_q) begin
                period_q <= {wd[wdog_pkg::P3_BIT], wd[2:0]};
            end
        end
    end

    // Interrupt enable: software write wins over the automatic clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ie_q <= 1'b0;
        end else if (clk_en) begin
            if (chip_reset) begin
                ie_q <= 1'b0;
            end else if (wr_ctl) begin
                ie_q <= wd[wdog_pkg::IE_BIT];
            end else if (timeout && wde_eff && ie_q) begin
                ie_q <= 1'b0;
            end
        end
    end

    // Interrupt flag: a timeout in the clearing cycle is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqf_q <= 1'b0;
        end else if (clk_en) begin
            if (timeout && ie_q) begin
                irqf_q <= 1'b1;
            end else if (irq_vector_ack || (wr_ctl && wd[wdog_pkg::IRQF_BIT])) begin
                irqf_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Reset-cause flags
    // ****************************************
    logic [2:0] rc_set;

    assign rc_set = {reset_event.dog | dog_reset_req, reset_event.brownout, reset_event.pin};

    // Zero written clears a flag, a new event in that cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_q  <= 3'h0;
            por_q <= 1'b1;
        end else if (clk_en) begin
            if (wr_rc) begin
                rc_q  <= (rc_q & wd[wdog_pkg::DOG_BIT:wdog_pkg::PIN_BIT]) | rc_set;
                por_q <= por_q & wd[wdog_pkg::POR_BIT];
            end else begin
                rc_q <= rc_q | rc_set;
            end
        end
    end

    // ****************************************
    // Timeout counter on oscillator ticks
    // ****************************************
    logic [20:0] cnt_q;
    logic [3:0]  code;
    logic [20:0] limit;

    assign code    = (period_q > wdog_pkg::PERIOD_MAX) ? wdog_pkg::PERIOD_MAX : period_q;
    assign limit   = (wdog_pkg::BASE_CYCLES << code) - 21'h0_0001;
    // Compare with >= so a period shortened mid-count still ends promptly,
    // instead of running on until the counter wraps
    assign timeout = running && tick && (cnt_q >= limit);

    // Restart on instruction, when stopped, and on any chip reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 21'h0_0000;
        end else if (clk_en) begin
            if (chip_reset || dog_restart || !running || timeout) begin
                cnt_q <= 21'h0_0000;
            end else if (tick) begin
                cnt_q <= cnt_q + 21'h0_0001;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Reset only when interrupt mode is off; irq gated by both enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dog_reset_req <= 1'b0;
            timeout_irq   <= 1'b0;
            wdog_running  <= 1'b0;
        end else if (clk_en) begin
            dog_reset_req <= timeout && wde_eff && !ie_q;
            timeout_irq   <= irqf_q && ie_q && global_irq_en;
            wdog_running  <= running;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk iff clk_en); endclocking
    default disable iff (!hresetn);

    a_unlock_hold: assert property ($rose(unlock_q) |-> unlock_q[*4])
        else $error("unlock window shorter than four cycles");
    a_unlock_close: assert property ((unlock_q && ucnt_q == 3'h1 && !open_now
        && !chip_reset) |=> !unlock_q)
        else $error("unlock window did not close");
    a_wde_guard: assert property ($fell(wde_q) |-> $past(unlock_q) || $past(chip_reset))
        else $error("enable cleared outside window");
    a_period_guard: assert property ($changed(period_q) |-> $past(unlock_q)
        || $past(chip_reset))
        else $error("period changed outside window");
    a_level2_on: assert property (lvl2 |-> ctl_rd[wdog_pkg::RUN_BIT] && running)
        else $error("higher level watchdog not running");
    a_flag_force: assert property ((rc_q[2] && !(wr_rc && !wd[3])) |=> wde_eff)
        else $error("dog flag did not force enable");
    a_reset_req: assert property ((timeout && wde_eff && !ie_q) |=> dog_reset_req
        ##1 !dog_reset_req)
        else $error("reset request missing or too long");
    a_ie_autoclr: assert property ((timeout && wde_eff && ie_q && !wr_ctl) |=> !ie_q
        && irqf_q)
        else $error("interrupt enable not cleared on timeout");
    a_irq_gate: assert property (timeout_irq |-> $past(irqf_q && ie_q && global_irq_en))
        else $error("interrupt without both enables");
    a_cause_upper: assert property (rc_rd[7:4] == 4'h0)
        else $error("cause register upper bits not zero");
    // Zero write clears the dog flag, one keeps it, and a new event always wins
    a_cause_clear: assert property (wr_rc |=> rc_q[2] == (($past(rc_q[2])
        && $past(wd[3])) || $past(rc_set[2])))
        else $error("dog flag clear or keep wrong");
    a_por_hold: assert property (!(wr_rc && !wd[wdog_pkg::POR_BIT])
        |=> por_q == $past(por_q))
        else $error("power-on flag changed without zero write");
    a_count_wrap: assert property (timeout |=> cnt_q == 21'h0_0000)
        else $error("counter not restarted after timeout");
    a_stop_idle: assert property (!running |=> cnt_q == 21'h0_0000)
        else $error("stopped counter not held at zero");
    a_restart_cnt: assert property (dog_restart |=> cnt_q == 21'h0_0000)
        else $error("restart instruction did not clear counter");
    // Set wins over both clears, so a timeout is never lost
    a_irqf_set: assert property ((timeout && ie_q) |=> irqf_q)
        else $error("interrupt flag not set on timeout");
    a_irqf_clear: assert property ((irqf_q && irq_vector_ack && !(timeout && ie_q))
        |=> !irqf_q)
        else $error("interrupt flag not cleared by vector");

    c_disable: cover property (open_now ##[1:4] (wr_ctl && !wd[wdog_pkg::RUN_BIT]) ##1 !wde_q);
    c_reset: cover property (dog_reset_req);
    c_irq: cover property (timeout_irq);
    c_level2_change: cover property (lvl2 && open_now);
    c_cause_clear: cover property (wr_rc && !wd[wdog_pkg::DOG_BIT] && rc_q[2]);
endmodule
`default_nettype wire

// >>> testbench/wdog_timed_config_tb_top.sv
// Self-checking bench for the watchdog with timed configuration
`timescale 1ns/10ps
`default_nettype none
module wdog_timed_config_tb_top;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic                   hclk, hresetn, clk_en, hsel, hwrite, fuse, wdog_osc;
    logic                   dog_restart, global_irq_en, irq_vector_ack, chip_reset;
    logic [7:0]             haddr;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [31:0]            hwdata, seed, hrdata;
    wdog_pkg::reset_event_t reset_event;
    logic                   hreadyout, hresp, timeout_irq, dog_reset_req, wdog_running;
    logic [7:0]             exp_q[$];
    logic                   rd_dp;
    logic [3:0]             p;
    int                     n_mismatch, tests_run, ticks, cyc, t;
    localparam logic [7:0]  C = wdog_pkg::CTL_ADDR;
    localparam logic [7:0]  R = wdog_pkg::RC_ADDR;

    wdog_timed_config dut_u (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .safety_level_fuse(fuse), .wdog_osc(wdog_osc), .dog_restart(dog_restart),
        .global_irq_en(global_irq_en), .irq_vector_ack(irq_vector_ack),
        .chip_reset(chip_reset), .reset_event(reset_event), .timeout_irq(timeout_irq),
        .dog_reset_req(dog_reset_req), .wdog_running(wdog_running)
    );

    // ****************************************
    // Clocks; the oscillator runs far above its real rate to keep timeouts short
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        wdog_osc = 1'b0;
        forever #110 wdog_osc = ~wdog_osc;
    end
    always @(posedge wdog_osc) ticks++;

    // Hang guard: a run far beyond the expected length is a failure
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            test_done();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Single AHB transfer; entered just after a rising edge, leaves just after one
    task automatic xfer(input logic wr, input logic [7:0] a, d, e);
        logic [31:0] r;
        r = rnd();
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {r[31:8], d};
        if (!wr) begin
            exp_q.push_back(e);
            rd_dp = 1'b1;
        end
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(1'b1, a, d, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, e);
        xfer(1'b0, a, 8'h00, e);
    endtask

    // Read data is judged mid data phase, where it has settled
    always @(negedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            rd_dp = 1'b0;
            check("hrdata", hrdata, {24'h0, exp_q.pop_front()});
        end
    end

    // Waits for a timeout event on the falling edge, then realigns to the rising edge
    task automatic wait_ev(input logic irq);
        int n;
        n = 0;
        while (n < 30000 && ((irq ? timeout_irq : dog_reset_req) !== 1'b1)) begin
            @(negedge hclk);
            n++;
        end
        t = ticks;
        @(posedge hclk);
    endtask
    task automatic lvl(input logic [31:0] e);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check("timeout_irq", timeout_irq, e);
        @(posedge hclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {hresetn, hsel, hwrite, fuse, dog_restart, global_irq_en} = '0;
        {irq_vector_ack, chip_reset, rd_dp, haddr, htrans, hwdata} = '0;
        reset_event = '0;
        clk_en = 1'b1;
        hsize = 3'b010;
        seed = 32'h0000_4019;
        {n_mismatch, tests_run, ticks, cyc} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(C, 8'h00);
        rd(R, 8'h01);
        rd(8'hF0, 8'h00);
        $display("test reset values done");
        // Enable without sequence, then locked clear and locked period change
        wr(C, 8'h08);
        rd(C, 8'h08);
        wr(C, 8'h00);
        wr(C, 8'h09);
        rd(C, 8'h08);
        wr(C, 8'h18);
        wr(C, 8'h07);
        repeat (6) @(posedge hclk);
        rd(C, 8'h07);
        wr(C, 8'h1F);
        repeat (6) @(posedge hclk);
        rd(C, 8'h0F);
        wr(C, 8'h00);
        rd(C, 8'h0F);
        wr(C, 8'h18);
        wr(C, 8'h00);
        $display("test timed sequence done");
        // Cause flags: zero clears, one keeps, upper nibble stays zero
        wr(R, 8'h00);
        rd(R, 8'h00);
        for (int i = 0; i < 3; i++) begin
            reset_event <= wdog_pkg::reset_event_t'(3'b100 >> i);
            @(posedge hclk);
            reset_event <= '0;
            rd(R, 8'h08 >> i);
            wr(R, 8'hFF);
            rd(R, 8'h08 >> i);
            rd(C, (i == 0) ? 8'h08 : 8'h00);
            wr(R, 8'h00);
            rd(R, 8'h00);
        end
        $display("test cause flags done");
        // Reset mode timeout at the shortest period
        wr(C, 8'h08);
        ticks = 0;
        wait_ev(1'b0);
        check("reset ticks", 32'(t >= 2047 && t <= 2049), 1);
        rd(R, 8'h08);
        chip_reset <= 1'b1;
        @(posedge hclk);
        chip_reset <= 1'b0;
        rd(C, 8'h08);
        wr(R, 8'h00);
        rd(C, 8'h00);
        $display("test reset mode done");
        // Interrupt mode: flag, global gate, vector clear
        global_irq_en <= 1'b1;
        wr(C, 8'h40);
        ticks = 0;
        wait_ev(1'b1);
        check("irq ticks", 32'(t >= 2047 && t <= 2050), 1);
        rd(C, 8'hC0);
        global_irq_en <= 1'b0;
        lvl(0);
        global_irq_en <= 1'b1;
        lvl(1);
        irq_vector_ack <= 1'b1;
        @(posedge hclk);
        irq_vector_ack <= 1'b0;
        lvl(0);
        // Both set: first timeout sets the flag but drops irq-enable in the same cycle, so no irq; second resets
        wr(C, 8'h48);
        dog_restart <= 1'b1;
        @(posedge hclk);
        dog_restart <= 1'b0;
        ticks = 0;
        wait_ev(1'b0);
        check("both ticks", 32'(t >= 4095 && t <= 4098), 1);
        rd(C, 8'h88);
        wr(C, 8'h80);
        rd(C, 8'h08);
        chip_reset <= 1'b1;
        @(posedge hclk);
        chip_reset <= 1'b0;
        wr(R, 8'h00);
        $display("test interrupt mode done");
        // Higher level: always on, period only through the sequence
        fuse <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(C, 8'h08);
        p = 4'(rnd() % 10);
        wr(C, 8'h18);
        wr(C, {2'b00, p[3], 2'b00, p[2:0]});
        repeat (6) @(posedge hclk);
        rd(C, {2'b00, p[3], 2'b01, p[2:0]});
        wr(C, 8'h00);
        rd(C, {2'b00, p[3], 2'b01, p[2:0]});
        // A frozen block must not age the unlock window; the bus is held off meanwhile
        wr(C, 8'h18);
        clk_en <= 1'b0;
        repeat (6) @(posedge hclk);
        check("hreadyout", hreadyout, 0);
        clk_en <= 1'b1;
        wr(C, 8'h00);
        repeat (6) @(posedge hclk);
        rd(C, 8'h08);
        check("wdog_running", wdog_running, 1);
        check("hresp", hresp, 0);
        repeat (4) @(posedge hclk);
        $display("test higher level done");
        test_done();
    end
endmodule
`default_nettype wire
